// ---- common/tof_result_regs.vh ----
`ifndef TOF_RESULT_REGS_VH
`define TOF_RESULT_REGS_VH

// ==========================================
// Register offsets
`define OFS_STOP3_FINE 6'h14
`define OFS_STOP3_COARSE 6'h15
`define OFS_STOP4_FINE 6'h16
`define OFS_STOP4_COARSE 6'h17
`define OFS_STOP5_FINE 6'h18
`define OFS_STOP5_COARSE 6'h19
`define OFS_SIXTH_FINE 6'h1A
`define OFS_CAL_ONE 6'h1B
`define OFS_FIRST 6'h14

// ==========================================
// Field layout
`define PARITY_BIT 23
`define FINE_MSB 22
`define COARSE_MSB 15
`define WORD_W 24
`define ZERO_WORD 24'h000000
`define ZERO_EXT 7'h00
`define NUM_WORDS 8
`define IDX_W 3

// ==========================================
// Result slot indices
`define SLOT_STOP3_FINE 3'h0
`define SLOT_STOP3_COARSE 3'h1
`define SLOT_STOP4_FINE 3'h2
`define SLOT_STOP4_COARSE 3'h3
`define SLOT_STOP5_FINE 3'h4
`define SLOT_STOP5_COARSE 3'h5
`define SLOT_SIXTH_FINE 3'h6
`define SLOT_CAL_ONE 3'h7

`endif

// ---- src/result_store.v ----
`timescale 1ns/1ps
`include "tof_result_regs.vh"

// ==========================================
// Result word memory with registered read data
module result_store #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire arst_n,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [WIDTH-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  integer i;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_r[i] <= {WIDTH{1'b0}};
      end
      rd_data <= {WIDTH{1'b0}};
    end else begin
      if (wr_en) begin
        mem_r[wr_addr] <= wr_data;
      end
      rd_data <= mem_r[rd_addr];
    end
  end
endmodule

// ---- src/tof_result_register_bank.v ----
`timescale 1ns/1ps
`include "tof_result_regs.vh"

module tof_result_register_bank (
  input wire SYS_CLK,
  input wire ARST_N,
  input wire LOAD_EN,
  input wire [2:0] LOAD_SLOT,
  input wire [22:0] LOAD_VALUE,
  input wire RD_EN,
  input wire WR_EN,
  input wire [5:0] ADDR,
  output reg [23:0] RD_DATA,
  output reg RD_VALID,
  output reg ADDR_HIT
);
  // ==========================================
  // Helper functions
  function parity_of;
    input [22:0] v;
    begin
      parity_of = ^v;
    end
  endfunction

  function is_coarse;
    input [2:0] slot;
    begin
      is_coarse = (slot == `SLOT_STOP3_COARSE) || (slot == `SLOT_STOP4_COARSE) ||
        (slot == `SLOT_STOP5_COARSE);
    end
  endfunction

  // ==========================================
  // Word formation
  reg [22:0] payload;
  reg [23:0] load_word;
  always @* begin
    if (is_coarse(LOAD_SLOT)) begin
      payload = {`ZERO_EXT, LOAD_VALUE[`COARSE_MSB:0]};
    end else begin
      payload = LOAD_VALUE[`FINE_MSB:0];
    end
    load_word = {parity_of(payload), payload};
  end

  // ==========================================
  // Address decode
  reg [2:0] rd_slot;
  reg hit;
  always @* begin
    rd_slot = `SLOT_STOP3_FINE;
    hit = 1'b1;
    if (ADDR == `OFS_STOP3_FINE) begin
      rd_slot = `SLOT_STOP3_FINE;
    end else if (ADDR == `OFS_STOP3_COARSE) begin
      rd_slot = `SLOT_STOP3_COARSE;
    end else if (ADDR == `OFS_STOP4_FINE) begin
      rd_slot = `SLOT_STOP4_FINE;
    end else if (ADDR == `OFS_STOP4_COARSE) begin
      rd_slot = `SLOT_STOP4_COARSE;
    end else if (ADDR == `OFS_STOP5_FINE) begin
      rd_slot = `SLOT_STOP5_FINE;
    end else if (ADDR == `OFS_STOP5_COARSE) begin
      rd_slot = `SLOT_STOP5_COARSE;
    end else if (ADDR == `OFS_SIXTH_FINE) begin
      rd_slot = `SLOT_SIXTH_FINE;
    end else if (ADDR == `OFS_CAL_ONE) begin
      rd_slot = `SLOT_CAL_ONE;
    end else begin
      hit = 1'b0;
    end
  end

  // ==========================================
  // Storage; host writes never reach it
  wire [23:0] store_q;
  result_store #(
    .WIDTH(`WORD_W),
    .DEPTH(`NUM_WORDS),
    .AW(`IDX_W)
  ) u_store (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .wr_en(LOAD_EN),
    .wr_addr(LOAD_SLOT),
    .wr_data(load_word),
    .rd_addr(rd_slot),
    .rd_data(store_q)
  );

  // ==========================================
  // Read response
  reg rd_pend_r;
  reg hit_pend_r;
  always @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_pend_r <= 1'b0;
      hit_pend_r <= 1'b0;
      RD_DATA <= `ZERO_WORD;
      RD_VALID <= 1'b0;
      ADDR_HIT <= 1'b0;
    end else begin
      rd_pend_r <= RD_EN && !WR_EN;
      hit_pend_r <= hit;
      RD_VALID <= rd_pend_r;
      if (rd_pend_r) begin
        RD_DATA <= hit_pend_r ? store_q : `ZERO_WORD;
        ADDR_HIT <= hit_pend_r;
      end
    end
  end
endmodule

// ---- verification/tof_result_register_bank_properties.sv ----
`timescale 1ns/1ps
module tof_result_checker (
  input wire SYS_CLK,
  input wire ARST_N,
  input wire RD_EN,
  input wire WR_EN,
  input wire [5:0] ADDR,
  input wire [23:0] RD_DATA,
  input wire RD_VALID,
  input wire ADDR_HIT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  sequence rd_take;
    RD_EN && !WR_EN;
  endsequence
  sequence rd_answer;
    ##2 RD_VALID;
  endsequence
  AST_RD_LAT: assert property (rd_take |-> rd_answer) else $error("late read");
  AST_NO_SPUR: assert property (RD_VALID |-> $past(RD_EN && !WR_EN, 2)) else $error("spur");
  AST_WR_IGN: assert property (WR_EN |-> ##2 !RD_VALID) else $error("write answered");
  AST_PARITY: assert property (RD_VALID |-> RD_DATA[23] == ^RD_DATA[22:0]) else $error("par");
  AST_HIT: assert property (RD_VALID |-> ADDR_HIT == ($past(ADDR, 2) >= 6'h14 &&
    $past(ADDR, 2) <= 6'h1B)) else $error("hit");
  AST_UNMAP: assert property (RD_VALID && !ADDR_HIT |-> RD_DATA == 24'h000000) else $error("um");
  AST_COARSE: assert property (RD_VALID && $past(ADDR[0] && ADDR != 6'h1B, 2)
    |-> RD_DATA[22:16] == 7'h00) else $error("coarse ext");
  AST_HOLD: assert property (!RD_VALID |-> $stable(RD_DATA)) else $error("data moved");
endmodule

bind tof_result_register_bank tof_result_checker i_chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
  .RD_EN(RD_EN), .WR_EN(WR_EN), .ADDR(ADDR), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .ADDR_HIT(ADDR_HIT));

// ---- verification/host_reader.sv ----
`timescale 1ns/1ps
module host_reader (
  input wire SYS_CLK,
  input wire RD_VALID,
  input wire ADDR_HIT,
  input wire [23:0] RD_DATA,
  output reg [25:0] answer
);
  // Samples the answer lines on every clock edge, whether RD_VALID is high or not
  always @(posedge SYS_CLK) begin
    answer <= {RD_VALID, ADDR_HIT, RD_DATA};
  end
endmodule

// ---- verification/tof_result_register_bank_tb.sv ----
`timescale 1ns/1ps
module tof_result_register_bank_tb;
  reg SYS_CLK = 0, ARST_N = 0, LOAD_EN = 0, RD_EN = 0, WR_EN = 0;
  reg [2:0] LOAD_SLOT = 3'h0;
  reg [22:0] LOAD_VALUE = 23'h000000;
  reg [5:0] ADDR = 6'h00;
  reg [22:0] model [0:7];
  wire [23:0] RD_DATA;
  wire RD_VALID, ADDR_HIT;
  wire [25:0] answer;
  integer num_errors = 0, checks = 0, seed = 32'hedc2, i, rnd;
  tof_result_register_bank i_tof_result_register_bank (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .LOAD_EN(LOAD_EN), .LOAD_SLOT(LOAD_SLOT), .LOAD_VALUE(LOAD_VALUE), .RD_EN(RD_EN),
    .WR_EN(WR_EN), .ADDR(ADDR), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .ADDR_HIT(ADDR_HIT));
  host_reader i_host_reader (.SYS_CLK(SYS_CLK), .RD_VALID(RD_VALID), .ADDR_HIT(ADDR_HIT),
    .RD_DATA(RD_DATA), .answer(answer));
  initial forever #50 SYS_CLK = ~SYS_CLK;
  task cmp(input [25:0] e, input [25:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("Error answer exp %h got %h", e, g);
      end
    end
  endtask
  task rd(input [5:0] a, input w);
    reg [22:0] v;
    begin
      v = model[a - 6'h14];
      @(posedge SYS_CLK) {RD_EN, WR_EN, ADDR} <= {1'b1, w, a};
      @(posedge SYS_CLK) {RD_EN, WR_EN} <= 2'h0;
      repeat (2) @(posedge SYS_CLK);
      #1;
      if (w) cmp(26'h0000000, {answer[25], 25'h0000000});
      else if (a >= 6'h14 && a <= 6'h1B) cmp({2'h3, ^v, v}, answer);
      else cmp(26'h2000000, answer);
    end
  endtask
  task sweep(input w, input integer n);
    begin
      for (i = 6'h13; i <= 6'h1C; i = i + 1) rd(i, w);
      $display("test %0d done", n);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    for (i = 0; i < 8; i = i + 1) model[i] = 23'h000000;
    repeat (12) @(posedge SYS_CLK);
    ARST_N <= 1;
    sweep(0, 1);
    for (i = 0; i < 8; i = i + 1) begin
      rnd = $random(seed);
      @(posedge SYS_CLK) {LOAD_EN, LOAD_SLOT, LOAD_VALUE} <= {1'b1, i[2:0], rnd[22:0]};
      @(posedge SYS_CLK) LOAD_EN <= 0;
      model[i] = (i % 2 && i != 7) ? {7'h00, LOAD_VALUE[15:0]} : LOAD_VALUE;
    end
    sweep(0, 2);
    sweep(1, 3);
    sweep(0, 4);
    report_and_stop;
  end
endmodule
